// ==== bench/tb_top.sv ====
// self-checking bench for the stop recovery and option control block
`timescale 1ns/10ps
module tb_top;
  import srcopt_pkg::*;

  // ==========================================
  // stimulus and observed ports
  logic                    ref_clk = 1'b0;
  logic                    arst_n = 1'b0;
  logic                    por_pulse = 1'b0;
  logic                    lvr_pulse = 1'b0;
  logic                    opt_we = 1'b0;
  srcopt_opt_t             opt_wdata = '0;
  logic                    stop_opcode = 1'b0;
  logic                    keypad_irq_pin = 1'b0;
  logic                    other_wake = 1'b0;
  srcopt_opt_t             opt_q;
  srcopt_ctl_t             ctl_q;
  logic                    bus_clk_en_q;
  logic [SRCOPT_AWU_W-1:0] awu_count_q;
  srcopt_opt_t             o;
  srcopt_opt_t             e;
  int                      failures = 0;
  int                      n_tests = 0;
  int                      seed = 32'hc341;
  int                      cycles = 0;
  int                      n;

  srcopt_top dut (
    .ref_clk        (ref_clk),
    .arst_n         (arst_n),
    .por_pulse      (por_pulse),
    .lvr_pulse      (lvr_pulse),
    .opt_we         (opt_we),
    .opt_wdata      (opt_wdata),
    .stop_opcode    (stop_opcode),
    .keypad_irq_pin (keypad_irq_pin),
    .other_wake     (other_wake),
    .opt_q          (opt_q),
    .ctl_q          (ctl_q),
    .bus_clk_en_q   (bus_clk_en_q),
    .awu_count_q    (awu_count_q)
  );

  initial
  begin
    forever #5 ref_clk = ~ref_clk;
  end

  // four recoveries of 4096 dominate the run
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      failures++;
      complete_run();
    end
  end

  // ==========================================
  // tasks
  task complete_run;
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task chk(input bit ok, input string m);
    n_tests++;
    if (!ok)
    begin
      failures++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask

  task wr(input srcopt_opt_t v);
    opt_we    <= 1'b1;
    opt_wdata <= v;
    @(posedge ref_clk);
    opt_we <= 1'b0;
    @(negedge ref_clk);
    chk(opt_q === v, "option bits");
    @(negedge ref_clk);
    chk(ctl_q.watchdog_enable === ~v.watchdog_disable, "watchdog");
    chk(ctl_q.lowvolt_monitor_power_on === ~v.lowvolt_monitor_power_off, "power");
    chk(ctl_q.lowvolt_5v_mode === v.lowvolt_range_select, "range");
    @(posedge ref_clk);
  endtask

  // edges from the call until cpu_hold reads low, cut short at 5000;
  // sampled on the falling edge so the count is free of edge races
  task hold(output int k);
    k = 0;
    do
    begin
      @(posedge ref_clk);
      k++;
      @(negedge ref_clk);
    end
    while (ctl_q.cpu_hold !== 1'b0 && k < 5000);
    @(posedge ref_clk);
  endtask

  task stop_in;
    stop_opcode <= 1'b1;
    @(posedge ref_clk);
    stop_opcode <= 1'b0;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    chk(ctl_q.in_stop === 1'b1, "stop entry");
    chk(awu_count_q <= 2, "wakeup count from zero");
    @(posedge ref_clk);
  endtask

  task wake(input bit kp, output int k);
    if (kp)
      keypad_irq_pin <= 1'b1;
    else
      other_wake <= 1'b1;
    @(posedge ref_clk);
    keypad_irq_pin <= 1'b0;
    other_wake     <= 1'b0;
    hold(k);
  endtask

  // ==========================================
  // main sequence
  initial
  begin
    repeat (10) @(posedge ref_clk);
    arst_n <= 1'b1;
    hold(n);
    chk(n >= 4090 && n <= 4104, "reset delay");
    n = 0;
    repeat (40)
    begin
      @(negedge ref_clk);
      n += (bus_clk_en_q === 1'b1);
    end
    chk(n == 10, "bus clock rate");
    @(posedge ref_clk);
    repeat (6)
    begin
      o = srcopt_opt_t'($random(seed));
      wr(o);
    end
    $display("test reset and options done");
    o = srcopt_opt_t'($random(seed));
    o.stop_enable = 1'b0;
    wr(o);
    stop_opcode <= 1'b1;
    @(posedge ref_clk);
    stop_opcode <= 1'b0;
    n = 0;
    repeat (4)
    begin
      @(negedge ref_clk);
      n += (ctl_q.illegal_opcode_reset === 1'b1);
      chk(ctl_q.in_stop === 1'b0, "illegal stop entered");
    end
    chk(n == 1, "illegal pulse");
    hold(n);
    $display("test illegal stop done");
    o = srcopt_opt_t'($random(seed));
    o.stop_enable = 1'b1;
    o.wakeup_timer_irq_enable = 1'b1;
    o.keypad_irq_mask = 1'b1;
    o.short_stop_recovery = 1'b1;
    wr(o);
    @(negedge ref_clk);
    chk(ctl_q.auto_wakeup_timer_run === 1'b0, "timer idle in run");
    @(posedge ref_clk);
    stop_in();
    repeat (40) @(posedge ref_clk);
    @(negedge ref_clk);
    chk(ctl_q.auto_wakeup_timer_run === 1'b1, "timer run");
    chk(awu_count_q >= 8 && awu_count_q <= 12, "timer count");
    @(posedge ref_clk);
    keypad_irq_pin <= 1'b1;
    repeat (3) @(posedge ref_clk);
    keypad_irq_pin <= 1'b0;
    repeat (10) @(posedge ref_clk);
    @(negedge ref_clk);
    chk(ctl_q.in_stop === 1'b1, "masked keypad woke");
    @(posedge ref_clk);
    wake(1'b0, n);
    chk(n >= 32 && n <= 40, "short recovery");
    stop_in();
    o.keypad_irq_mask = 1'b0;
    o.short_stop_recovery = 1'b0;
    wr(o);
    wake(1'b1, n);
    chk(n >= 4096 && n <= 4106, "long recovery");
    $display("test stop and wake done");
    o.short_stop_recovery = 1'b1;
    o.lowvolt_range_select = 1'b1;
    o.wakeup_timer_irq_enable = 1'b0;
    wr(o);
    stop_in();
    repeat (8) @(posedge ref_clk);
    @(negedge ref_clk);
    chk(ctl_q.auto_wakeup_timer_run === 1'b0, "timer ran while disabled");
    chk(awu_count_q === SRCOPT_AWU_ZERO, "timer counted while disabled");
    @(posedge ref_clk);
    lvr_pulse <= 1'b1;
    @(posedge ref_clk);
    lvr_pulse <= 1'b0;
    hold(n);
    chk(n >= 4096 && n <= 4106, "low-voltage exit");
    e = SRCOPT_OPT_RST;
    e.lowvolt_range_select = 1'b1;
    chk(opt_q === e, "range kept");
    por_pulse <= 1'b1;
    @(posedge ref_clk);
    por_pulse <= 1'b0;
    hold(n);
    chk(n >= 4096 && n <= 4106, "power-on delay");
    chk(opt_q === SRCOPT_OPT_RST, "range cleared");
    $display("test resets done");
    complete_run();
  end
endmodule

// ==== hw/srcopt_pkg.sv ====
// package: constants and carrier types for the stop recovery and option control block
package srcopt_pkg;

  // ==========================================
  // stabilization timing, in 4x bus clock cycles
  localparam int unsigned SRCOPT_SHORT_REC_CYC = 32;
  localparam int unsigned SRCOPT_LONG_REC_CYC  = 4096;
  localparam int unsigned SRCOPT_CNT_W         = 13;
  localparam logic [SRCOPT_CNT_W-1:0] SRCOPT_SHORT_LOAD = 13'h0020;
  localparam logic [SRCOPT_CNT_W-1:0] SRCOPT_LONG_LOAD  = 13'h1000;
  localparam logic [SRCOPT_CNT_W-1:0] SRCOPT_CNT_ZERO   = 13'h0000;

  // ==========================================
  // bus clock divider and wakeup timer
  localparam int unsigned SRCOPT_BUS_DIV   = 4;
  localparam logic [1:0]  SRCOPT_DIV_LAST  = 2'h3;
  localparam int unsigned SRCOPT_AWU_W     = 16;
  localparam logic [SRCOPT_AWU_W-1:0] SRCOPT_AWU_ZERO = 16'h0000;

  // ==========================================
  // option bits written by software
  typedef struct packed {
    logic wakeup_timer_irq_enable;
    logic keypad_irq_mask;
    logic lowvolt_monitor_power_off;
    logic lowvolt_range_select;
    logic short_stop_recovery;
    logic stop_enable;
    logic watchdog_disable;
  } srcopt_opt_t;

  localparam srcopt_opt_t SRCOPT_OPT_RST = '0;

  // ==========================================
  // control outputs
  typedef struct packed {
    logic watchdog_enable;
    logic lowvolt_monitor_power_on;
    logic lowvolt_5v_mode;
    logic auto_wakeup_timer_run;
    logic cpu_hold;
    logic in_stop;
    logic illegal_opcode_reset;
  } srcopt_ctl_t;

  typedef enum logic [1:0] {
    SRCOPT_RUN,
    SRCOPT_STOP,
    SRCOPT_RECOVER
  } srcopt_state_t;

endpackage

// ==== hw/srcopt_sync.sv ====
// two flip-flop synchroniser for the asynchronous keypad wake source
`timescale 1ns/10ps
module srcopt_sync
  import srcopt_pkg::*;
(
  input  wire  logic ref_clk,
  input  wire  logic arst_n,
  input  wire  logic async_in,
  output logic       sync_out
);

  logic meta_q;

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_q   <= 1'b0;
      sync_out <= 1'b0;
    end
    else
    begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// ==== hw/srcopt_top.sv ====
// stop-mode entry, recovery delay, wakeup timer and option-bit control
`timescale 1ns/10ps
module srcopt_top
  import srcopt_pkg::*;
(
  input  wire  logic        ref_clk,
  input  wire  logic        arst_n,
  input  wire  logic        por_pulse,
  input  wire  logic        lvr_pulse,
  input  wire  logic        opt_we,
  input  wire  srcopt_opt_t opt_wdata,
  input  wire  logic        stop_opcode,
  input  wire  logic        keypad_irq_pin,
  input  wire  logic        other_wake,
  output srcopt_opt_t       opt_q,
  output srcopt_ctl_t       ctl_q,
  output logic              bus_clk_en_q,
  output logic [SRCOPT_AWU_W-1:0] awu_count_q
);

  srcopt_state_t          state_q;
  logic [SRCOPT_CNT_W-1:0] rec_cnt_q;
  logic [1:0]             div_q;
  logic                   keypad_sync;
  logic                   wake;
  logic                   stop_go;
  logic                   stop_bad;

  // ==========================================
  // wake source conditioning
  srcopt_sync u_kbd_sync (
    .ref_clk  (ref_clk),
    .arst_n   (arst_n),
    .async_in (keypad_irq_pin),
    .sync_out (keypad_sync)
  );

  assign wake = (keypad_sync & ~opt_q.keypad_irq_mask) | other_wake;

  // stop enable decides execute or illegal
  assign stop_go  = (state_q == SRCOPT_RUN) && stop_opcode && opt_q.stop_enable;
  assign stop_bad = (state_q == SRCOPT_RUN) && stop_opcode && !opt_q.stop_enable;

  // ==========================================
  // option register; range select survives low-voltage resets only
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      opt_q <= SRCOPT_OPT_RST;
    else if (por_pulse)
      opt_q <= SRCOPT_OPT_RST;
    else if (lvr_pulse)
    begin
      // range select kept on low-voltage reset
      opt_q <= SRCOPT_OPT_RST;
      opt_q.lowvolt_range_select <= opt_q.lowvolt_range_select;
    end
    else if (opt_we)
      opt_q <= opt_wdata;
  end

  // ==========================================
  // bus clock divider
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      div_q        <= 2'h0;
      bus_clk_en_q <= 1'b0;
    end
    else
    begin
      div_q        <= div_q + 2'h1;
      bus_clk_en_q <= (div_q == SRCOPT_DIV_LAST);
    end
  end

  // ==========================================
  // stop / recovery sequencer
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q   <= SRCOPT_RECOVER;
      rec_cnt_q <= SRCOPT_LONG_LOAD;
    end
    else if (por_pulse || lvr_pulse)
    begin
      // long delay after power-on or low-voltage reset
      state_q   <= SRCOPT_RECOVER;
      rec_cnt_q <= SRCOPT_LONG_LOAD;
    end
    else
    begin
      case (state_q)
        SRCOPT_RUN:
        begin
          if (stop_go)
            state_q <= SRCOPT_STOP;
        end
        SRCOPT_STOP:
        begin
          if (wake)
          begin
            state_q   <= SRCOPT_RECOVER;
            rec_cnt_q <= opt_q.short_stop_recovery ? SRCOPT_SHORT_LOAD : SRCOPT_LONG_LOAD;
          end
        end
        SRCOPT_RECOVER:
        begin
          if (rec_cnt_q == SRCOPT_CNT_ZERO + 13'h0001)
            state_q <= SRCOPT_RUN;
          rec_cnt_q <= rec_cnt_q - 13'h0001;
        end
        default:
        begin
          state_q <= SRCOPT_RUN;
        end
      endcase
    end
  end

  // ==========================================
  // wakeup timer counter
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      awu_count_q <= SRCOPT_AWU_ZERO;
    else if (stop_go)
      awu_count_q <= SRCOPT_AWU_ZERO;
    // counts only in stop when enabled
    else if (state_q == SRCOPT_STOP && opt_q.wakeup_timer_irq_enable && bus_clk_en_q)
      awu_count_q <= awu_count_q + 16'h0001;
  end

  // ==========================================
  // registered control outputs
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      ctl_q <= '0;
    else
    begin
      ctl_q.watchdog_enable          <= ~opt_q.watchdog_disable;
      ctl_q.lowvolt_monitor_power_on <= ~opt_q.lowvolt_monitor_power_off;
      ctl_q.lowvolt_5v_mode          <= opt_q.lowvolt_range_select;
      ctl_q.auto_wakeup_timer_run    <= (state_q == SRCOPT_STOP) &&
                                        opt_q.wakeup_timer_irq_enable;
      ctl_q.cpu_hold                 <= (state_q != SRCOPT_RUN);
      ctl_q.in_stop                  <= (state_q == SRCOPT_STOP);
      ctl_q.illegal_opcode_reset     <= stop_bad;
    end
  end

  // ==========================================
  // checks
  property p_stop_illegal;
    @(posedge ref_clk) disable iff (!arst_n)
    stop_bad && !por_pulse && !lvr_pulse |=> ctl_q.illegal_opcode_reset && state_q == SRCOPT_RUN;
  endproperty
  a_stop_illegal: assert property (p_stop_illegal)
    else $error("illegal stop not reported");

  property p_stop_enter;
    @(posedge ref_clk) disable iff (!arst_n)
    stop_go && !por_pulse && !lvr_pulse |=> state_q == SRCOPT_STOP ##1 ctl_q.in_stop;
  endproperty
  a_stop_enter: assert property (p_stop_enter)
    else $error("stop not entered");

  property p_awu_zero;
    @(posedge ref_clk) disable iff (!arst_n)
    stop_go |=> awu_count_q == SRCOPT_AWU_ZERO;
  endproperty
  a_awu_zero: assert property (p_awu_zero)
    else $error("wakeup counter not cleared");

  property p_awu_idle;
    @(posedge ref_clk) disable iff (!arst_n)
    state_q != SRCOPT_STOP |=> $stable(awu_count_q) || $past(stop_go);
  endproperty
  a_awu_idle: assert property (p_awu_idle)
    else $error("wakeup counter moved outside stop");

  property p_short_rec;
    @(posedge ref_clk) disable iff (!arst_n || por_pulse || lvr_pulse)
    state_q == SRCOPT_STOP && wake && opt_q.short_stop_recovery
      |=> rec_cnt_q == SRCOPT_SHORT_LOAD ##32 state_q == SRCOPT_RUN;
  endproperty
  a_short_rec: assert property (p_short_rec)
    else $error("short recovery length wrong");

  property p_long_lvr;
    @(posedge ref_clk) disable iff (!arst_n)
    lvr_pulse |=> rec_cnt_q == SRCOPT_LONG_LOAD && state_q == SRCOPT_RECOVER;
  endproperty
  a_long_lvr: assert property (p_long_lvr)
    else $error("low-voltage exit not long");

  property p_range_keep;
    @(posedge ref_clk) disable iff (!arst_n)
    lvr_pulse && !por_pulse |=> $stable(opt_q.lowvolt_range_select);
  endproperty
  a_range_keep: assert property (p_range_keep)
    else $error("range select lost on non power-on reset");

  // ctl_q still shows its reset value one edge after release, so skip that edge
  property p_wdog;
    @(posedge ref_clk) disable iff (!arst_n)
    $past(arst_n) |-> ctl_q.watchdog_enable == !$past(opt_q.watchdog_disable);
  endproperty
  a_wdog: assert property (p_wdog)
    else $error("watchdog gate wrong");

  property p_kbd_mask;
    @(posedge ref_clk) disable iff (!arst_n || por_pulse || lvr_pulse)
    state_q == SRCOPT_STOP && !other_wake && opt_q.keypad_irq_mask |=> state_q == SRCOPT_STOP;
  endproperty
  a_kbd_mask: assert property (p_kbd_mask)
    else $error("masked keypad woke the device");

  property p_bus_div;
    @(posedge ref_clk) disable iff (!arst_n)
    bus_clk_en_q |=> !bus_clk_en_q [*3] ##1 bus_clk_en_q;
  endproperty
  a_bus_div: assert property (p_bus_div)
    else $error("bus enable not one in four");

endmodule
